// ==== core/ppd_regs.svh ====
// constant definitions for the parallel port control word decoder
`ifndef PPD_REGS_SVH
`define PPD_REGS_SVH

// control byte classification patterns
`define PPD_VEC_TAG_BIT 0
`define PPD_VEC_TAG_VAL 1'h0
`define PPD_MODE_PAT 4'hF
`define PPD_ICW_PAT 4'h7
`define PPD_ENA_PAT 4'h3

// field positions inside control bytes
`define PPD_MODE_HI 7
`define PPD_MODE_LO 6
`define PPD_ICW_EN_BIT 7
`define PPD_ICW_AND_BIT 6
`define PPD_ICW_HIGH_BIT 5
`define PPD_ICW_MASKF_BIT 4

// reset values
`define PPD_VEC_RST 7'h00
`define PPD_MODE_RST 2'h1
`define PPD_DIR_RST 8'hFF
`define PPD_MASK_RST 8'hFF
`define PPD_OUT_RST 8'h00

`endif

// ==== core/ppd_pkg.sv ====
// types shared by the control word decoder modules
package ppd_pkg;

   // operating modes, encoded as the two mode bits
   typedef enum logic [1:0] {
      PPD_MODE_OUTPUT = 2'h0,
      PPD_MODE_INPUT = 2'h1,
      PPD_MODE_BIDIR = 2'h2,
      PPD_MODE_BITCTL = 2'h3
   } ppd_mode_type;

   // what the next control-address byte is taken as
   typedef enum logic [2:0] {
      PPD_EXP_CMD = 3'h1,
      PPD_EXP_DIR = 3'h2,
      PPD_EXP_MASK = 3'h4
   } ppd_expect_type;

endpackage

// ==== core/ppd_cond_if.sv ====
// carrier between decoder and bit-control condition evaluator
`timescale 1ns/10ps
interface ppd_cond_if;
   logic [7:0] direction;
   logic [7:0] monitor_exclude_bit;
   logic [7:0] out_data;
   logic [7:0] in_data;
   logic and_mode;
   logic active_high;
   logic bit_mode;
   logic cond_rise;

   modport ctrl (
      output direction, monitor_exclude_bit, out_data, in_data,
      output and_mode, active_high, bit_mode,
      input cond_rise
   );
   modport eval (
      input direction, monitor_exclude_bit, out_data, in_data,
      input and_mode, active_high, bit_mode,
      output cond_rise
   );
endinterface

// ==== core/ppd_cond.sv ====
// bit-control mode logical condition evaluator with edge detect
`timescale 1ns/10ps
module ppd_cond (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   ppd_cond_if.eval cif
);

   logic [7:0] line_val;
   logic [7:0] line_act;
   logic cond_now;
   logic cond_reg;
   logic cond_next;
   logic rise_reg;
   logic rise_next;

   // per-line value: output register for outputs, pins for inputs
   always_comb begin
      line_val = (cif.direction & cif.in_data) | (~cif.direction & cif.out_data); // RULE10
      line_act = cif.active_high ? line_val : ~line_val;
   end

   // combine monitored lines, zero mask bit means monitored
   always_comb begin
      if (&cif.monitor_exclude_bit) begin
         cond_now = 1'b0;
      end else if (cif.and_mode) begin
         cond_now = &(line_act | cif.monitor_exclude_bit); // RULE6
      end else begin
         cond_now = |(line_act & ~cif.monitor_exclude_bit); // RULE6
      end
      cond_next = cif.bit_mode & cond_now;
      rise_next = cond_next & ~cond_reg; // RULE14
   end

   // condition history and false-to-true pulse
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cond_reg <= 1'b0;
         rise_reg <= 1'b0;
      end else begin
         cond_reg <= cond_next;
         rise_reg <= rise_next;
      end
   end

   assign cif.cond_rise = rise_reg;

endmodule // ppd_cond

// ==== core/ppd_decoder.sv ====
// per-port control word interpreter of an 8-bit parallel port
//
// Contract
// RULE1 - even control byte loads vector bits seven-one
// RULE2 - low nibble ones selects mode from top bits
// RULE3 - after bit-control mode, next byte sets directions
// RULE4 - low nibble 0111 sets interrupt control fields
// RULE5 - mask-follows flag makes next byte the mask
// RULE6 - zero mask bit monitors line, one excludes
// RULE7 - low nibble 0011 changes only interrupt enable
// RULE8 - enable at next cycle-one rise, not acknowledge
// RULE9 - with mask, enable at cycle-one rise after mask
// RULE10 - condition uses output register for output lines
// RULE11 - priority output frozen while cycle-one active
// RULE12 - at most four devices per plain chain
// RULE13 - host picks port and control/data with selects
// RULE14 - request only on condition false-to-true change
// RULE15 - bit-control read mixes output and input registers
// RULE16 - expected direction/mask byte beats command decode
// RULE17 - unmatched control bytes change nothing
`timescale 1ns/10ps
`include "ppd_regs.svh"
module ppd_decoder (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ctrl_wr_i,
   input wire logic data_wr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [7:0] port_pins_i,
   input wire logic machine_cycle_one_n_i,
   input wire logic io_request_n_i,
   input wire logic priority_enable_in_i,
   input wire logic service_done_i,
   output logic [7:0] rd_data_o,
   output logic [7:0] port_out_o,
   output logic [7:0] port_oe_o,
   output logic [7:0] vector_o,
   output logic [1:0] mode_o,
   output logic [7:0] direction_o,
   output logic [7:0] mask_o,
   output logic int_enable_o,
   output logic int_req_o,
   output logic priority_enable_out_o
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [10:0] meta_reg;
   logic [10:0] sync_reg;
   logic m1_prev_reg;
   logic [7:0] pins_s;
   logic m1_n_s;
   logic io_request_n_n_s;
   logic iei_s;
   logic m1_rise;
   logic ack_now;

   // two flops for every pin input
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= 11'h7FF;
         sync_reg <= 11'h7FF;
         m1_prev_reg <= 1'b1;
      end else begin
         meta_reg <= {priority_enable_in_i, io_request_n_i, machine_cycle_one_n_i, port_pins_i};
         sync_reg <= meta_reg;
         m1_prev_reg <= sync_reg[8];
      end
   end

   // decoded bus cycle events
   always_comb begin
      pins_s = sync_reg[7:0];
      m1_n_s = sync_reg[8];
      io_request_n_n_s = sync_reg[9];
      iei_s = sync_reg[10];
      m1_rise = m1_n_s & ~m1_prev_reg;
      ack_now = ~m1_n_s & ~io_request_n_n_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control word decode

   ppd_pkg::ppd_expect_type exp_reg;
   ppd_pkg::ppd_expect_type exp_next;
   ppd_pkg::ppd_mode_type mode_reg;
   ppd_pkg::ppd_mode_type mode_next;
   logic [6:0] vec_reg;
   logic [6:0] vec_next;
   logic [7:0] dir_reg;
   logic [7:0] dir_next;
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic [7:0] out_reg;
   logic [7:0] out_next;
   logic and_reg;
   logic and_next;
   logic high_reg;
   logic high_next;
   logic en_reg;
   logic en_next;
   logic arm_reg;
   logic arm_next;
   logic arm_excl_reg;
   logic arm_excl_next;
   logic mask_arm_reg;
   logic mask_arm_next;
   logic ack_cyc_reg;
   logic ack_cyc_next;

   // next-state for decoder, configuration and enable arming
   always_comb begin
      exp_next = exp_reg;
      mode_next = mode_reg;
      vec_next = vec_reg;
      dir_next = dir_reg;
      mask_next = mask_reg;
      out_next = data_wr_i ? wr_data_i : out_reg;
      and_next = and_reg;
      high_next = high_reg;
      en_next = en_reg;
      arm_next = arm_reg;
      arm_excl_next = arm_excl_reg;
      mask_arm_next = mask_arm_reg;
      ack_cyc_next = m1_n_s ? 1'b0 : (ack_cyc_reg | ack_now);
      // armed enable takes effect at cycle-one rise
      if (m1_rise && arm_reg) begin
         if (!(arm_excl_reg && ack_cyc_reg)) begin // RULE8
            en_next = 1'b1; // RULE9
            arm_next = 1'b0;
         end
      end
      if (ctrl_wr_i) begin
         unique case (exp_reg)
            ppd_pkg::PPD_EXP_DIR: begin
               dir_next = wr_data_i; // RULE3 RULE16
               exp_next = ppd_pkg::PPD_EXP_CMD;
            end
            ppd_pkg::PPD_EXP_MASK: begin
               mask_next = wr_data_i; // RULE5 RULE16
               exp_next = ppd_pkg::PPD_EXP_CMD;
               arm_next = mask_arm_reg; // RULE9
               arm_excl_next = 1'b0;
               mask_arm_next = 1'b0;
            end
            ppd_pkg::PPD_EXP_CMD: begin
               if (wr_data_i[`PPD_VEC_TAG_BIT] == `PPD_VEC_TAG_VAL) begin
                  vec_next = wr_data_i[7:1]; // RULE1
               end else if (wr_data_i[3:0] == `PPD_MODE_PAT) begin
                  mode_next = ppd_pkg::ppd_mode_type'(wr_data_i[`PPD_MODE_HI:`PPD_MODE_LO]); // RULE2
                  if (mode_next == ppd_pkg::PPD_MODE_BITCTL) begin
                     exp_next = ppd_pkg::PPD_EXP_DIR; // RULE3
                  end
               end else if (wr_data_i[3:0] == `PPD_ICW_PAT) begin
                  and_next = wr_data_i[`PPD_ICW_AND_BIT]; // RULE4
                  high_next = wr_data_i[`PPD_ICW_HIGH_BIT]; // RULE4
                  en_next = 1'b0;
                  arm_next = 1'b0;
                  if (wr_data_i[`PPD_ICW_MASKF_BIT]) begin
                     exp_next = ppd_pkg::PPD_EXP_MASK; // RULE5
                     mask_arm_next = wr_data_i[`PPD_ICW_EN_BIT];
                  end else begin
                     arm_next = wr_data_i[`PPD_ICW_EN_BIT]; // RULE8
                     arm_excl_next = 1'b1;
                  end
               end else if (wr_data_i[3:0] == `PPD_ENA_PAT) begin
                  en_next = wr_data_i[`PPD_ICW_EN_BIT]; // RULE7
                  arm_next = 1'b0;
               end
               // any other byte leaves everything as it was RULE17
            end
         endcase
      end
   end

   // decoder and configuration registers
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         exp_reg <= ppd_pkg::PPD_EXP_CMD;
         mode_reg <= ppd_pkg::ppd_mode_type'(`PPD_MODE_RST);
         vec_reg <= `PPD_VEC_RST;
         dir_reg <= `PPD_DIR_RST;
         mask_reg <= `PPD_MASK_RST;
         out_reg <= `PPD_OUT_RST;
         and_reg <= 1'b0;
         high_reg <= 1'b0;
         en_reg <= 1'b0;
         arm_reg <= 1'b0;
         arm_excl_reg <= 1'b0;
         mask_arm_reg <= 1'b0;
         ack_cyc_reg <= 1'b0;
      end else begin
         exp_reg <= exp_next;
         mode_reg <= mode_next;
         vec_reg <= vec_next;
         dir_reg <= dir_next;
         mask_reg <= mask_next;
         out_reg <= out_next;
         and_reg <= and_next;
         high_reg <= high_next;
         en_reg <= en_next;
         arm_reg <= arm_next;
         arm_excl_reg <= arm_excl_next;
         mask_arm_reg <= mask_arm_next;
         ack_cyc_reg <= ack_cyc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit-control condition evaluator

   ppd_cond_if cif ();

   // feed current configuration to the evaluator
   always_comb begin
      cif.direction = dir_reg;
      cif.monitor_exclude_bit = mask_reg;
      cif.out_data = out_reg;
      cif.in_data = pins_s;
      cif.and_mode = and_reg;
      cif.active_high = high_reg;
      cif.bit_mode = (mode_reg == ppd_pkg::PPD_MODE_BITCTL);
   end

   ppd_cond u_cond (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .cif(cif.eval)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request and priority chain

   logic pend_reg;
   logic pend_next;
   logic req_reg;
   logic req_next;
   logic svc_reg;
   logic svc_next;
   logic ieo_reg;
   logic ieo_next;
   logic take;

   // requests held off while cycle-one is active
   always_comb begin
      take = pend_reg & m1_n_s & ~req_reg; // RULE11
      pend_next = (pend_reg & ~take) | (cif.cond_rise & en_reg); // RULE14
      req_next = req_reg | take;
      svc_next = svc_reg;
      // clear before set, so an acknowledge in the same cycle wins
      if (service_done_i && iei_s) begin
         svc_next = 1'b0;
      end
      if (ack_now && iei_s && req_reg) begin
         req_next = 1'b0;
         svc_next = 1'b1;
      end
      if (m1_n_s) begin
         ieo_next = iei_s & ~req_next & ~svc_next; // RULE11
      end else begin
         ieo_next = ieo_reg; // RULE11
      end
   end

   // request state and chain output
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_reg <= 1'b0;
         req_reg <= 1'b0;
         svc_reg <= 1'b0;
         ieo_reg <= 1'b0;
      end else begin
         pend_reg <= pend_next;
         req_reg <= req_next;
         svc_reg <= svc_next;
         ieo_reg <= ieo_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data and pin drive

   logic [7:0] rd_reg;
   logic [7:0] rd_next;
   logic [7:0] oe_reg;
   logic [7:0] oe_next;

   // read mux and output enables per mode
   always_comb begin
      unique case (mode_reg)
         ppd_pkg::PPD_MODE_OUTPUT: begin
            rd_next = out_reg;
            oe_next = 8'hFF;
         end
         ppd_pkg::PPD_MODE_BITCTL: begin
            rd_next = (dir_reg & pins_s) | (~dir_reg & out_reg); // RULE15
            oe_next = ~dir_reg; // RULE3
         end
         default: begin
            rd_next = pins_s;
            oe_next = 8'h00;
         end
      endcase
   end

   // registered read data and enables
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_reg <= 8'h00;
         oe_reg <= 8'h00;
      end else begin
         rd_reg <= rd_next;
         oe_reg <= oe_next;
      end
   end

   // outputs straight from flops
   assign rd_data_o = rd_reg;
   assign port_out_o = out_reg;
   assign port_oe_o = oe_reg;
   assign vector_o = {vec_reg, 1'b0};
   assign mode_o = mode_reg;
   assign direction_o = dir_reg;
   assign mask_o = mask_reg;
   assign int_enable_o = en_reg;
   assign int_req_o = req_reg;
   assign priority_enable_out_o = ieo_reg;

endmodule // ppd_decoder

// ==== sim/ppd_decoder_assertions.sv ====
// checker for the control word decoder ports
`timescale 1ns/10ps
module ppd_decoder_chk (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ctrl_wr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic machine_cycle_one_n_i,
   input wire logic [7:0] vector_o,
   input wire logic [1:0] mode_o,
   input wire logic [7:0] direction_o,
   input wire logic [7:0] mask_o,
   input wire logic int_enable_o,
   input wire logic int_req_o,
   input wire logic priority_enable_out_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic exp_dir_reg;
   logic exp_mask_reg;
   logic pend;
   logic cmd;
   assign pend = exp_dir_reg | exp_mask_reg;
   assign cmd = ctrl_wr_i & !pend;
   ////////////////////////////////////////////////////////////////////////////////
   // tracks which byte is owed next
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         exp_dir_reg <= 1'b0;
         exp_mask_reg <= 1'b0;
      end else if (ctrl_wr_i) begin
         exp_dir_reg <= cmd && wr_data_i[3:0] == 4'hF && wr_data_i[7:6] == 2'h3;
         exp_mask_reg <= cmd && wr_data_i[3:0] == 4'h7 && wr_data_i[4];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   chk_vector_load: assert property (cmd && !wr_data_i[0] |=> vector_o == {$past(wr_data_i[7:1]), 1'b0})
      else $error("vector not loaded");
   chk_mode_load: assert property (cmd && wr_data_i[3:0] == 4'hF |=> mode_o == $past(wr_data_i[7:6]))
      else $error("mode not loaded");
   chk_dir_load: assert property (ctrl_wr_i && exp_dir_reg |=> direction_o == $past(wr_data_i))
      else $error("direction not loaded");
   chk_mask_load: assert property (ctrl_wr_i && exp_mask_reg |=> mask_o == $past(wr_data_i))
      else $error("mask not loaded");
   chk_enable_only: assert property (cmd && wr_data_i[3:0] == 4'h3
      |=> int_enable_o == $past(wr_data_i[7]) && $stable(mask_o))
      else $error("enable-only word misapplied");
   chk_icw_holdoff: assert property (cmd && wr_data_i[3:0] == 4'h7 |=> !int_enable_o)
      else $error("enable not held off after control word");
   chk_ignore_byte: assert property (cmd && wr_data_i[0] && wr_data_i[3:0] != 4'hF
      && wr_data_i[3:0] != 4'h7 && wr_data_i[3:0] != 4'h3
      |=> $stable(vector_o) && $stable(mode_o) && $stable(mask_o) && $stable(direction_o))
      else $error("unmatched byte changed state");
   chk_prio_frozen: assert property ((!machine_cycle_one_n_i) [*5] |-> $stable(priority_enable_out_o))
      else $error("chain enable moved during cycle one");
   chk_req_mode: assert property ($rose(int_req_o) |-> mode_o == 2'h3 && int_enable_o)
      else $error("request outside enabled bit-control mode");
endmodule // ppd_decoder_chk

bind ppd_decoder ppd_decoder_chk ppd_decoder_chk_inst (
   .ref_clk_i(ref_clk_i),
   .arst_n_i(arst_n_i),
   .ctrl_wr_i(ctrl_wr_i),
   .wr_data_i(wr_data_i),
   .machine_cycle_one_n_i(machine_cycle_one_n_i),
   .vector_o(vector_o),
   .mode_o(mode_o),
   .direction_o(direction_o),
   .mask_o(mask_o),
   .int_enable_o(int_enable_o),
   .int_req_o(int_req_o),
   .priority_enable_out_o(priority_enable_out_o)
);

// ==== sim/ppd_host_model.sv ====
// host side model making cycle-one and acknowledge cycles
`timescale 1ns/10ps
module ppd_host_model (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   input wire logic ack_i,
   output logic machine_cycle_one_n_o,
   output logic io_request_n_o
);
   logic [2:0] cnt_reg, cnt_next;
   logic ack_reg, ack_next;
   ////////////////////////////////////////////////////////////////////////////////
   // six-cycle strobe, io request in its last four when acknowledging
   always_comb begin
      cnt_next = (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : (start_i ? 3'h6 : 3'h0);
      ack_next = (cnt_reg == 3'h0) ? ack_i : ack_reg;
   end
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= 3'h0;
         ack_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         ack_reg <= ack_next;
      end
   end
   // io request starts two cycles into cycle one, leaving the chain time to settle
   assign machine_cycle_one_n_o = (cnt_reg == 3'h0);
   assign io_request_n_o = !(ack_reg && cnt_reg != 3'h0 && cnt_reg < 3'h5);
endmodule // ppd_host_model

// ==== sim/ppd_decoder_tb.sv ====
// testbench for the control word decoder
`timescale 1ns/10ps
module ppd_decoder_tb;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ctrl_wr = 1'b0, data_wr = 1'b0, done = 1'b0, start = 1'b0, ack = 1'b0, priority_enable_in = 1'b1;
   logic [7:0] wdat = 8'h00, pins = 8'h00;
   logic m1_n, io_request_n_n, en, req, prio;
   logic [7:0] rd, pout, oe, vec, dir, mask;
   logic [1:0] mode;
   int miscompares = 0;
   int checks = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   ppd_host_model ppd_host_model_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .start_i(start), .ack_i(ack), .machine_cycle_one_n_o(m1_n), .io_request_n_o(io_request_n_n));
   ppd_decoder ppd_decoder_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .ctrl_wr_i(ctrl_wr), .data_wr_i(data_wr), .wr_data_i(wdat), .port_pins_i(pins),
      .machine_cycle_one_n_i(m1_n), .io_request_n_i(io_request_n_n), .priority_enable_in_i(priority_enable_in),
      .service_done_i(done), .rd_data_o(rd), .port_out_o(pout), .port_oe_o(oe),
      .vector_o(vec), .mode_o(mode), .direction_o(dir), .mask_o(mask),
      .int_enable_o(en), .int_req_o(req), .priority_enable_out_o(prio));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask
   // one write cycle, control or data address
   task automatic wr(input logic ctl, input logic [7:0] b);
      @(posedge ref_clk_i);
      ctrl_wr <= ctl;
      data_wr <= !ctl;
      wdat <= b;
      @(posedge ref_clk_i);
      ctrl_wr <= 1'b0;
      data_wr <= 1'b0;
      #1;
   endtask
   task automatic m1(input logic a);
      @(posedge ref_clk_i);
      start <= 1'b1;
      ack <= a;
      @(posedge ref_clk_i);
      start <= 1'b0;
      repeat (14) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wait_req();
      for (int i = 0; i < 30 && req !== 1'b1; i++) @(posedge ref_clk_i);
      #1;
      chk("int_req", 8'h01, {7'h0, req});
      if (req !== 1'b1) end_sim();
   endtask
   task automatic settle(input logic [7:0] p);
      @(posedge ref_clk_i);
      pins <= p;
      repeat (12) @(posedge ref_clk_i);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      #1;
      chk("vector", 8'h00, vec);
      chk("mode", 8'h01, {6'h0, mode});
      chk("dir", 8'hFF, dir);
      chk("mask", 8'hFF, mask);
      chk("int_en", 8'h00, {7'h0, en});
      wr(1'b1, 8'hA4);
      chk("vector", 8'hA4, vec);
      wr(1'b1, 8'h05);
      chk("vector", 8'hA4, vec);
      chk("mode", 8'h01, {6'h0, mode});
      for (int m = 0; m < 3; m++) begin
         wr(1'b1, {m[1:0], 6'h3F});
         chk("mode", m[7:0], {6'h0, mode});
         repeat (2) @(posedge ref_clk_i);
         #1;
         chk("oe", (m == 0) ? 8'hFF : 8'h00, oe);
      end
      wr(1'b1, 8'hCF);
      chk("mode", 8'h03, {6'h0, mode});
      wr(1'b1, 8'h29);
      chk("dir", 8'h29, dir);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("oe", 8'hD6, oe);
      wr(1'b1, 8'h37);
      wr(1'b1, 8'h03);
      chk("mask", 8'h03, mask);
      chk("int_en", 8'h00, {7'h0, en});
      wr(1'b1, 8'h87);
      m1(1'b1);
      chk("int_en", 8'h00, {7'h0, en});
      m1(1'b0);
      chk("int_en", 8'h01, {7'h0, en});
      wr(1'b1, 8'h03);
      chk("int_en", 8'h00, {7'h0, en});
      wr(1'b1, 8'h83);
      chk("int_en", 8'h01, {7'h0, en});
      chk("mask", 8'h03, mask);
      wr(1'b1, 8'hB7);
      wr(1'b1, 8'hD6);
      chk("mask", 8'hD6, mask);
      chk("int_en", 8'h00, {7'h0, en});
      m1(1'b1);
      chk("int_en", 8'h01, {7'h0, en});
      settle(8'h02);
      chk("int_req", 8'h00, {7'h0, req});
      settle(8'h08);
      wait_req();
      m1(1'b1);
      chk("int_req", 8'h00, {7'h0, req});
      chk("prio", 8'h00, {7'h0, prio});
      @(posedge ref_clk_i);
      done <= 1'b1;
      @(posedge ref_clk_i);
      done <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk("prio", 8'h01, {7'h0, prio});
      // chain input low must pull the chain output low
      @(posedge ref_clk_i);
      priority_enable_in <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk("prio", 8'h00, {7'h0, prio});
      @(posedge ref_clk_i);
      priority_enable_in <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk("prio", 8'h01, {7'h0, prio});
      settle(8'h28);
      chk("int_req", 8'h00, {7'h0, req});
      wr(1'b0, 8'h80);
      chk("port_out", 8'h80, pout);
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk("rd_data", 8'hA8, rd);
      wr(1'b0, 8'h00);
      settle(8'h00);
      wr(1'b1, 8'hB7);
      wr(1'b1, 8'h56);
      m1(1'b0);
      wr(1'b0, 8'h80);
      wait_req();
      // acknowledge, then AND combining over lines zero and three
      m1(1'b1);
      chk("int_req", 8'h00, {7'h0, req});
      wr(1'b1, 8'hF7);
      wr(1'b1, 8'hF6);
      m1(1'b0);
      chk("int_en", 8'h01, {7'h0, en});
      settle(8'h08);
      chk("int_req", 8'h00, {7'h0, req});
      settle(8'h09);
      wait_req();
      end_sim();
   end
endmodule // ppd_decoder_tb
